// ### spm_core_model.sv
`timescale 1ns/100ps
`default_nettype none
module spm_core_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic cpu_halt,
  input wire logic drop,
  input wire logic [3:0] req,
  output logic [3:0] line_q
);
  // Level held until the core runs again or drop is raised
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) line_q <= 4'h0;
    else if (drop || !cpu_halt) line_q <= 4'h0;
    else line_q <= line_q | req;
endmodule : spm_core_model
`default_nettype wire

// ### spm_pkg.sv
package spm_pkg;
  // APB byte addresses
  localparam logic [7:0] SPM_ADDR_CTRL = 8'h00;
  localparam logic [7:0] SPM_ADDR_PRR = 8'h04;
  localparam logic [7:0] SPM_ADDR_STAT = 8'h08;
  localparam logic [7:0] SPM_ADDR_CFG = 8'h0C;
  // Control register fields
  localparam int SPM_BIT_BROWNOUT_SLEEP_OFF = 7;
  localparam int SPM_BIT_SE = 5;
  localparam int SPM_BIT_SM_HI = 4;
  localparam int SPM_BIT_SM_LO = 3;
  localparam int SPM_BIT_BROWNOUT_SLEEP_UNLOCK = 2;
  // Power reduction fields
  localparam int SPM_BIT_PR_TIM1 = 3;
  localparam int SPM_BIT_PR_TIM0 = 2;
  localparam int SPM_BIT_PR_USI = 1;
  localparam int SPM_BIT_PR_ADC = 0;
  localparam logic [7:0] SPM_CTRL_RST = 8'h00;
  localparam logic [3:0] SPM_PRR_RST = 4'h0;
  // Timing
  localparam logic [2:0] SPM_UNLOCK_CYC = 3'h4;
  localparam logic [2:0] SPM_BROWNOUT_SLEEP_OFF_DELAY_CYC = 3'h3;
  localparam logic [2:0] SPM_BROWNOUT_SLEEP_OFF_HOLD_CYC = 3'h3;
  localparam logic [3:0] SPM_STBY_WAKE_CYC = 4'h6;
  localparam logic [3:0] SPM_INT_HALT_CYC = 4'h4;
  localparam int SPM_CLK_MHZ = 250;
  localparam int SPM_BOD_WAKE_US = 60;
  localparam int SPM_BOD_WAKE_CYC = SPM_BOD_WAKE_US * SPM_CLK_MHZ;
  localparam logic [3:0] SPM_STARTUP_CYC = 4'h2;
  typedef enum logic [1:0] {
    SPM_MODE_IDLE,
    SPM_MODE_ADCNR,
    SPM_MODE_PDOWN,
    SPM_MODE_STBY
  } spm_mode_t;
  typedef enum logic [1:0] {
    SPM_ST_RUN,
    SPM_ST_SLEEP,
    SPM_ST_WAKE
  } spm_state_t;
endpackage : spm_pkg

// ### spm_sleep_power_manager.sv
// Notes on behaviour
// RULE1 - Sleep only when armed and sleep executes
// RULE2 - Mode 00 idle: stop cpu, flash
// RULE3 - Mode 01: stop io, cpu, flash
// RULE4 - Mode 10 power-down: stop oscillator, all clocks
// RULE5 - Mode 11 with crystal: standby, oscillator runs
// RULE6 - Standby wake resumes after six cycles
// RULE7 - Interrupt wake halts four extra cycles
// RULE8 - Register file and memory kept
// RULE9 - Reset wakes, restarts at reset vector
// RULE10 - Level wake source holds its level
// RULE11 - Idle wakes on external and internal interrupts
// RULE12 - Enabled ADC converts on idle/noise entry
// RULE13 - Noise mode wakes on listed sources only
// RULE14 - Power-down wakes on listed sources only
// RULE15 - Armed brown-out off after deep entry
// RULE16 - Brown-out re-enabled on every wake
// RULE17 - Brown-out wake waits about 60us
// RULE18 - Brown-out off bit resets to zero
// RULE19 - Stopped peripheral frozen, registers blocked
// RULE20 - Clearing bit resumes peripheral state
// RULE21 - Deep modes disable digital input buffers
// RULE22 - Deep modes disable comparator automatically
// RULE23 - Software unlocks brown-out off within four
// RULE24 - Brown-out off active after three, clears after three
// RULE25 - Power reduction bits: tim1, tim0, serial, adc
// RULE26 - Unarmed sleep is single-cycle no-op
//
// Design decisions made here: the register offsets and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
module spm_sleep_power_manager
#(
  parameter int BOD_WAKE_CYC = spm_pkg::SPM_BOD_WAKE_CYC
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sleep_exec,
  input wire logic xtal_selected,
  input wire logic adc_enabled,
  input wire logic irq_pending,
  input wire logic irq_adc_done,
  input wire logic irq_spm_ready,
  input wire logic external_interrupt_zero,
  input wire logic pin_change_irq,
  input wire logic wdt_irq,
  input wire logic ext_reset_req,
  input wire logic wdt_reset_req,
  input wire logic bod_reset_req,
  output logic sleep_nop,
  output logic cpu_halt,
  output logic clk_cpu_en,
  output logic clk_flash_en,
  output logic clk_io_en,
  output logic clk_adc_en,
  output logic osc_en,
  output logic adc_autostart,
  output logic brownout_detector_en,
  output logic comparator_disable,
  output logic input_buf_disable,
  output logic wake_to_reset_vector,
  output logic timer_one_clk_en,
  output logic timer_zero_clk_en,
  output logic serial_if_clk_en,
  output logic adc_periph_clk_en,
  output logic [3:0] periph_reg_block
);
  import spm_pkg::*;

  typedef struct packed {
    logic sleep_arm;
    logic [1:0] sleep_mode_sel;
    logic brownout_sleep_unlock;
    logic [2:0] unlock_cnt;
    logic brownout_sleep_off_pend;
    logic [2:0] brownout_sleep_off_cnt;
    logic brownout_sleep_off;
    logic [3:0] power_reduction_reg;
    spm_state_t st;
    spm_mode_t mode;
    logic bod_off;
    logic bod_slept;
    logic by_reset;
    logic [31:0] wake_cnt;
    logic autostart;
    logic nop;
    logic [31:0] rdata;
  } spm_state_s_t;

  spm_state_s_t q, d;

  // Wake sources are pins or other domains; two-stage sync
  logic [8:0] wk_meta_q, wk_sync_q;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wk_meta_q <= 9'h000;
      wk_sync_q <= 9'h000;
    end
    else if (clk_en)
    begin
      wk_meta_q <= {
        irq_pending,
        irq_adc_done,
        irq_spm_ready,
        external_interrupt_zero,
        pin_change_irq,
        wdt_irq,
        ext_reset_req,
        wdt_reset_req,
        bod_reset_req
      };
      wk_sync_q <= wk_meta_q;
    end
  end

  logic s_irq, s_adc, s_spm, s_external_interrupt_zero, s_pc, s_wdt, s_rst;
  assign s_irq = wk_sync_q[8];
  assign s_adc = wk_sync_q[7];
  assign s_spm = wk_sync_q[6];
  assign s_external_interrupt_zero = wk_sync_q[5];
  assign s_pc = wk_sync_q[4];
  assign s_wdt = wk_sync_q[3];
  assign s_rst = |wk_sync_q[2:0];

  logic wr_acc, rd_acc, ctrl_wr, brownout_sleep_off_req;
  logic wake_irq;
  logic [7:0] wb;
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && !penable && !pwrite;
  assign wb = pwdata[7:0];
  assign ctrl_wr = wr_acc && paddr == SPM_ADDR_CTRL;
  // Off step: off bit written to one, unlock bit to zero, inside the unlock window
  assign brownout_sleep_off_req = ctrl_wr && wb[SPM_BIT_BROWNOUT_SLEEP_OFF] && !wb[SPM_BIT_BROWNOUT_SLEEP_UNLOCK]
                    && q.brownout_sleep_unlock; // [RULE23]

  always_comb
  begin
    d = q;
    d.nop = 1'b0;
    d.autostart = 1'b0;
    // Per-mode allowed wake events
    case (q.mode)
      SPM_MODE_IDLE:
      begin
        wake_irq = s_irq || s_external_interrupt_zero || s_pc || s_wdt; // [RULE11]
      end
      SPM_MODE_ADCNR:
      begin
        wake_irq = s_adc || s_spm || s_external_interrupt_zero || s_pc || s_wdt; // [RULE13]
      end
      SPM_MODE_PDOWN:
      begin
        wake_irq = s_external_interrupt_zero || s_pc || s_wdt; // [RULE14]
      end
      SPM_MODE_STBY:
      begin
        // Same sources as power-down; the oscillator and the wake delay differ
        wake_irq = s_external_interrupt_zero || s_pc || s_wdt;
      end
      default:
      begin
        wake_irq = 1'b0;
      end
    endcase
    // Control write; the unlock window restarts on a write setting both unlock and off bits, any other control write closes it
    if (ctrl_wr)
    begin
      d.sleep_arm = wb[SPM_BIT_SE];
      d.sleep_mode_sel = wb[SPM_BIT_SM_HI:SPM_BIT_SM_LO];
      d.brownout_sleep_unlock = wb[SPM_BIT_BROWNOUT_SLEEP_UNLOCK] && wb[SPM_BIT_BROWNOUT_SLEEP_OFF];
      d.unlock_cnt = SPM_UNLOCK_CYC;
    end
    else if (q.unlock_cnt != 3'h0)
    begin
      d.unlock_cnt = q.unlock_cnt - 3'h1;
      if (q.unlock_cnt == 3'h1)
      begin
        // Window over: a late second write is ignored
        d.brownout_sleep_unlock = 1'b0;
      end
    end
    if (wr_acc && paddr == SPM_ADDR_PRR)
    begin
      d.power_reduction_reg = wb[3:0]; // [RULE25]
    end
    // Off bit: active three cycles after set, then self-clears
    if (brownout_sleep_off_req)
    begin
      d.brownout_sleep_off_pend = 1'b1;
      d.brownout_sleep_off_cnt = SPM_BROWNOUT_SLEEP_OFF_DELAY_CYC;
      d.brownout_sleep_unlock = 1'b0;
    end
    else if (q.brownout_sleep_off_pend)
    begin
      d.brownout_sleep_off_cnt = q.brownout_sleep_off_cnt - 3'h1;
      if (q.brownout_sleep_off_cnt == 3'h1)
      begin
        d.brownout_sleep_off_pend = 1'b0;
        d.brownout_sleep_off = 1'b1;
        d.brownout_sleep_off_cnt = SPM_BROWNOUT_SLEEP_OFF_HOLD_CYC;
      end
    end
    else if (q.brownout_sleep_off)
    begin
      d.brownout_sleep_off_cnt = q.brownout_sleep_off_cnt - 3'h1;
      if (q.brownout_sleep_off_cnt == 3'h1)
      begin
        d.brownout_sleep_off = 1'b0; // [RULE24]
      end
    end
    case (q.st)
      SPM_ST_RUN:
      begin
        if (sleep_exec && !q.sleep_arm)
        begin
          d.nop = 1'b1; // [RULE26]
        end
        else if (sleep_exec && !(q.sleep_mode_sel == 2'h3 && !xtal_selected)) // [RULE1] [RULE5]
        begin
          d.st = SPM_ST_SLEEP;
          d.mode = spm_mode_t'(q.sleep_mode_sel);
          d.autostart = adc_enabled && !q.sleep_mode_sel[1]; // [RULE12]
          d.bod_off = q.brownout_sleep_off && q.sleep_mode_sel[1]; // [RULE15]
          d.bod_slept = d.bod_off;
        end
        else if (sleep_exec)
        begin
          // Standby without a crystal is refused like an unarmed sleep
          d.nop = 1'b1;
        end
      end
      SPM_ST_SLEEP:
      begin
        if (s_rst || wake_irq)
        begin
          d.st = SPM_ST_WAKE;
          d.by_reset = s_rst; // [RULE9]
          d.bod_off = 1'b0; // [RULE16]
          if (q.bod_slept)
          begin
            // Detector needs its settling time before code runs
            d.wake_cnt = 32'(BOD_WAKE_CYC); // [RULE17]
          end
          else if (q.mode == SPM_MODE_STBY)
          begin
            d.wake_cnt = 32'(SPM_STBY_WAKE_CYC); // [RULE6]
          end
          else if (q.mode == SPM_MODE_PDOWN)
          begin
            d.wake_cnt = 32'(SPM_STARTUP_CYC);
          end
          else
          begin
            d.wake_cnt = 32'h0;
          end
          if (!s_rst)
          begin
            d.wake_cnt = d.wake_cnt + 32'(SPM_INT_HALT_CYC); // [RULE7]
          end
        end
      end
      SPM_ST_WAKE:
      begin
        if (q.wake_cnt <= 32'h1)
        begin
          d.st = SPM_ST_RUN;
          d.bod_slept = 1'b0;
        end
        else
        begin
          d.wake_cnt = q.wake_cnt - 32'h1;
        end
      end
      default:
      begin
        d.st = SPM_ST_RUN;
      end
    endcase
    // Clear sleep arm on reset wake, as after any reset
    if (q.st == SPM_ST_SLEEP && s_rst)
    begin
      d.sleep_arm = 1'b0;
      d.sleep_mode_sel = 2'h0;
    end
    // Captured in the setup phase so it stands through the access edge
    if (rd_acc)
    begin
      case (paddr)
        SPM_ADDR_CTRL:
        begin
          d.rdata = {
            24'h0,
            q.brownout_sleep_off,
            1'b0,
            q.sleep_arm,
            q.sleep_mode_sel,
            q.brownout_sleep_unlock,
            2'h0
          };
        end
        SPM_ADDR_PRR:
        begin
          d.rdata = {28'h0, q.power_reduction_reg};
        end
        SPM_ADDR_STAT:
        begin
          d.rdata = {26'h0, q.by_reset, q.bod_off, q.mode, q.st};
        end
        default:
        begin
          d.rdata = 32'h0;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      q <= '0;
      q.st <= SPM_ST_RUN;
      q.mode <= SPM_MODE_IDLE;
      q.brownout_sleep_off <= 1'b0; // [RULE18]
      q.power_reduction_reg <= SPM_PRR_RST;
    end
    else if (clk_en)
    begin
      q <= d;
    end
  end

  logic sleeping, deep, io_stop;
  assign sleeping = q.st != SPM_ST_RUN;
  assign deep = q.st == SPM_ST_SLEEP && q.mode[1];
  assign io_stop = q.st == SPM_ST_SLEEP && q.mode != SPM_MODE_IDLE;

  // Halting clocks only gates; register file and SRAM keep contents
  assign cpu_halt = sleeping; // [RULE8]
  assign clk_cpu_en = !sleeping; // [RULE2]
  assign clk_flash_en = !sleeping;
  assign clk_io_en = !io_stop; // [RULE3]
  assign clk_adc_en = !deep; // [RULE4]
  assign osc_en = !(q.st == SPM_ST_SLEEP && q.mode == SPM_MODE_PDOWN);
  assign input_buf_disable = deep; // [RULE21]
  assign comparator_disable = deep; // [RULE22]
  assign brownout_detector_en = !q.bod_off;
  assign adc_autostart = q.autostart;
  assign sleep_nop = q.nop;
  assign wake_to_reset_vector = q.st == SPM_ST_WAKE && q.by_reset;
  // Gating freezes state; re-enable continues where it stopped
  assign timer_one_clk_en = !q.power_reduction_reg[SPM_BIT_PR_TIM1] && !io_stop; // [RULE19]
  assign timer_zero_clk_en = !q.power_reduction_reg[SPM_BIT_PR_TIM0] && !io_stop; // [RULE20]
  assign serial_if_clk_en = !q.power_reduction_reg[SPM_BIT_PR_USI] && !io_stop;
  assign adc_periph_clk_en = !q.power_reduction_reg[SPM_BIT_PR_ADC] && !deep;
  assign periph_reg_block = q.power_reduction_reg;
  // External level wake sources must hold their level, see sync
  assign prdata = q.rdata;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
endmodule : spm_sleep_power_manager
`default_nettype wire

// ### spm_sleep_power_manager_props.sv
`timescale 1ns/100ps
`default_nettype none
module spm_sleep_power_manager_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic sleep_nop,
  input wire logic cpu_halt,
  input wire logic clk_cpu_en,
  input wire logic clk_flash_en,
  input wire logic clk_io_en,
  input wire logic clk_adc_en,
  input wire logic osc_en,
  input wire logic adc_autostart,
  input wire logic brownout_detector_en,
  input wire logic comparator_disable,
  input wire logic input_buf_disable,
  input wire logic wake_to_reset_vector,
  input wire logic timer_one_clk_en,
  input wire logic [3:0] periph_reg_block
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_no_err: assert property (pready && !pslverr) else $error("apb answer wrong");
  a_run_clocks: assert property (!cpu_halt |-> clk_cpu_en && clk_flash_en && osc_en)
    else $error("cpu clock off while running");
  a_deep_gating: assert property (input_buf_disable |-> !clk_io_en && !clk_adc_en)
    else $error("buffers off with clocks on");
  a_cmp_buf_pair: assert property (comparator_disable == input_buf_disable)
    else $error("comparator gating differs");
  a_osc_off_deep: assert property (!osc_en |-> input_buf_disable && cpu_halt)
    else $error("oscillator off outside deep sleep");
  a_nop_no_halt: assert property (sleep_nop |-> !cpu_halt)
    else $error("nop with halt");
  a_autostart_adc: assert property (adc_autostart |-> cpu_halt && clk_adc_en && !clk_cpu_en)
    else $error("autostart outside sleep");
  a_bod_off_deep: assert property (!brownout_detector_en |-> comparator_disable)
    else $error("brown-out off outside deep sleep");
  a_reset_vec: assert property (wake_to_reset_vector |-> cpu_halt)
    else $error("reset vector while running");
  a_prr_stop: assert property (periph_reg_block[3] |-> !timer_one_clk_en)
    else $error("timer one clock runs");
  a_halt_min: assert property ($rose(cpu_halt) |-> cpu_halt[*3])
    else $error("halt too short");
endmodule : spm_sleep_power_manager_props
bind spm_sleep_power_manager spm_sleep_power_manager_props u_props (.*);
`default_nettype wire

// ### tb_sleep_power_manager.sv
`timescale 1ns/100ps
`default_nettype none
module tb_sleep_power_manager;
  import spm_pkg::*;
  `define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
    $display("mismatch %s exp %0h got %0h", n, e, g); end end
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, sleep_exec = 0;
  logic xtal = 1, ext_rst = 0, drop = 0, pready, sleep_nop, cpu_halt, ck, io, ac, os;
  logic brownout_detector, cmpd, bufd, rvec, t1, t0, si, ad, adc_as;
  logic adc_en = 1, spm_rdy = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [3:0] req = 0, src, blk;
  int n_errors = 0, comparisons = 0, n_nop = 0, n_as = 0, n_rv = 0, n;
  logic [3:0] cks [4] = '{4'h7, 4'h3, 4'h0, 4'h1};
  logic [3:0] wk [4] = '{4'h1, 4'h2, 4'h4, 4'h8};
  logic [3:0] nw [4] = '{4'h0, 4'h1, 4'h2, 4'h1};
  int su [4] = '{0, 0, SPM_STARTUP_CYC, SPM_STBY_WAKE_CYC};
  spm_sleep_power_manager #(.BOD_WAKE_CYC(20)) u_dut (.pclk(pclk), .presetn(presetn),
    .clk_en(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(), .sleep_exec(sleep_exec),
    .xtal_selected(xtal), .adc_enabled(adc_en), .irq_pending(src[0]), .irq_adc_done(src[1]),
    .irq_spm_ready(spm_rdy), .external_interrupt_zero(src[2]), .pin_change_irq(src[3]),
    .wdt_irq(1'b0), .ext_reset_req(ext_rst), .wdt_reset_req(1'b0), .bod_reset_req(1'b0),
    .sleep_nop(sleep_nop), .cpu_halt(cpu_halt), .clk_cpu_en(ck), .clk_flash_en(),
    .clk_io_en(io), .clk_adc_en(ac), .osc_en(os), .adc_autostart(adc_as),
    .brownout_detector_en(brownout_detector), .comparator_disable(cmpd), .input_buf_disable(bufd),
    .wake_to_reset_vector(rvec), .timer_one_clk_en(t1), .timer_zero_clk_en(t0),
    .serial_if_clk_en(si), .adc_periph_clk_en(ad), .periph_reg_block(blk));
  spm_core_model u_core (.pclk(pclk), .presetn(presetn), .cpu_halt(cpu_halt), .drop(drop),
    .req(req), .line_q(src));
  initial forever #2 pclk = ~pclk;
  // Pulses counted mid-cycle, away from the launching edge
  always @(negedge pclk)
  begin
    if (sleep_nop === 1'b1) n_nop++;
    if (adc_as === 1'b1) n_as++;
    if (rvec === 1'b1) n_rv++;
  end
  task test_done;
    if (n_errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : test_done
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 0;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    psel <= 0; penable <= 0;
    #1;
  endtask : apb
  task slp(input logic [7:0] c, input int d);
    apb(1, SPM_ADDR_CTRL, {24'h0, c});
    repeat (d) @(posedge pclk);
    sleep_exec <= 1;
    @(posedge pclk);
    sleep_exec <= 0;
    repeat (2) @(posedge pclk);
    #1;
  endtask : slp
  task run_wait;
    n = 0;
    while (cpu_halt !== 1'b0 && n < 300)
    begin
      @(posedge pclk);
      n++;
    end
  endtask : run_wait
  task pulse(input logic [3:0] s);
    @(posedge pclk);
    req <= s;
    @(posedge pclk);
    req <= 0;
  endtask : pulse
  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1;
    apb(0, SPM_ADDR_CTRL, 0); `CHK("ctrl_rst", 32'h0, rd)
    apb(0, SPM_ADDR_CFG, 0); `CHK("reserved", 32'h0, rd)
    apb(0, 8'h10, 0); `CHK("unmapped", 32'h0, rd)
    for (int i = 0; i < 4; i++)
    begin
      apb(1, SPM_ADDR_PRR, 32'h1 << i); `CHK("prr_blk", 4'h1 << i, blk)
      `CHK("prr_clk", ~(4'h1 << i), {t1, t0, si, ad})
      apb(0, SPM_ADDR_PRR, 0); `CHK("prr_rd", 32'h1 << i, rd)
    end
    apb(1, SPM_ADDR_PRR, 0); `CHK("prr_clr", 4'hF, {t1, t0, si, ad})
    slp(8'h10, 1); `CHK("unarmed", 1'b0, cpu_halt)
    xtal <= 0;
    slp(8'h38, 1); `CHK("stby_noxtal", 1'b0, cpu_halt)
    `CHK("nops", 2, n_nop)
    xtal <= 1;
    for (int m = 0; m < 4; m++)
    begin
      slp(8'h20 | (m << 3), 1); `CHK("domains", cks[m], {ck, io, ac, os})
      `CHK("deep_gate", (m > 1) ? 2'h3 : 2'h0, {cmpd, bufd})
      if (nw[m] != 0)
      begin
        pulse(nw[m]);
        repeat (12) @(posedge pclk);
        `CHK("no_wake", 1'b1, cpu_halt)
        drop <= 1;
        @(posedge pclk);
        drop <= 0;
      end
      pulse(wk[m]);
      run_wait; `CHK("wake_len", 1'b1, n >= su[m] + SPM_INT_HALT_CYC)
      `CHK("woke", 1'b0, cpu_halt)
    end
    `CHK("autostart", 2, n_as)
    adc_en <= 0;
    slp(8'h20, 1);
    pulse(4'h1);
    run_wait;
    slp(8'h28, 1);
    spm_rdy <= 1;
    run_wait;
    spm_rdy <= 0; `CHK("spm_wake", 1'b0, cpu_halt)
    `CHK("no_autostart", 2, n_as)
    adc_en <= 1;
    slp(8'h30, 1);
    ext_rst <= 1;
    run_wait;
    ext_rst <= 0; `CHK("rst_vec", 1'b1, n_rv > 0)
    apb(1, SPM_ADDR_CTRL, 32'hB4);
    slp(8'hB0, 3); `CHK("bod_off", 1'b0, brownout_detector)
    pulse(4'h4);
    run_wait; `CHK("bod_wait", 1'b1, n >= 20)
    `CHK("bod_on", 1'b1, brownout_detector)
    apb(0, SPM_ADDR_CTRL, 0); `CHK("brownout_sleep_off_clr", 1'b0, rd[SPM_BIT_BROWNOUT_SLEEP_OFF])
    test_done;
  end
  initial
  begin
    #40000;
    n_errors++;
    test_done;
  end
endmodule : tb_sleep_power_manager
`default_nettype wire
